// ===== rtl/cal_cycle_counter.sv
// Counter of calibration clock cycles for one run
`timescale 1ns/1ps
module cal_cycle_counter
  import vco_cal_pkg::*;
#(
  parameter int unsigned CYCLES = CAL_CYCLES
) (
  input  wire logic clk,
  input  wire logic arst_n,
  input  wire logic clear,
  input  wire logic run,
  input  wire logic tick,
  output logic      finished
);

  localparam logic [CAL_CNT_W-1:0] LAST = CAL_CNT_W'(CYCLES - 1);

  logic [CAL_CNT_W-1:0] count_reg;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      count_reg <= '0;
      finished  <= 1'b0;
    end else if (clear) begin
      count_reg <= '0;
      finished  <= 1'b0;
    end else if (run && tick) begin
      if (count_reg == LAST) begin
        count_reg <= '0;
        finished  <= 1'b1;
      end else begin
        count_reg <= count_reg + 13'h0001;
        finished  <= 1'b0;
      end
    end else begin
      finished <= 1'b0;
    end
  end

  a_run_length: assert property (@(posedge clk) disable iff (!arst_n)
    finished |-> $past(count_reg) == LAST && $past(tick))
    else $error("calibration ended at wrong cycle count");

endmodule

// ===== rtl/cal_tick_gen.sv
// Phase-compare clock sampler and calibration clock divider
`timescale 1ns/1ps
module cal_tick_gen
  import vco_cal_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       arst_n,
  input  wire logic       phase_compare_clock,
  input  wire logic [1:0] div_sel,
  input  wire logic       restart,
  output logic            tick
);

  // ----------------------------------------------------------------
  // Divisor decode
  // ----------------------------------------------------------------
  function automatic logic [DIV_CNT_W-1:0] div_value(input logic [1:0] sel);
    case (sel)
      DIV_SEL_2:  div_value = DIV_VAL_2;
      DIV_SEL_4:  div_value = DIV_VAL_4;
      DIV_SEL_8:  div_value = DIV_VAL_8;
      DIV_SEL_16: div_value = DIV_VAL_16;
      default:    div_value = DIV_VAL_16;
    endcase
  endfunction

  logic                 sync1_reg;
  logic                 sync2_reg;
  logic                 edge_hist_reg;
  logic                 rise;
  logic [DIV_CNT_W-1:0] div_cnt_reg;
  logic [DIV_CNT_W-1:0] div_last;

  // ----------------------------------------------------------------
  // Pin synchroniser
  // ----------------------------------------------------------------
  // Phase-compare rate must stay well below half of clk
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sync1_reg     <= 1'b0;
      sync2_reg     <= 1'b0;
      edge_hist_reg <= 1'b0;
    end else begin
      sync1_reg     <= phase_compare_clock;
      sync2_reg     <= sync1_reg;
      edge_hist_reg <= sync2_reg;
    end
  end

  assign rise     = sync2_reg & ~edge_hist_reg;
  assign div_last = div_value(div_sel) - 5'h01;

  // ----------------------------------------------------------------
  // Divider
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      div_cnt_reg <= '0;
      tick        <= 1'b0;
    end else if (restart) begin
      div_cnt_reg <= '0;
      tick        <= 1'b0;
    end else if (rise) begin
      if (div_cnt_reg >= div_last) begin
        div_cnt_reg <= '0;
        tick        <= 1'b1;
      end else begin
        div_cnt_reg <= div_cnt_reg + 5'h01;
        tick        <= 1'b0;
      end
    end else begin
      tick <= 1'b0;
    end
  end

  // A divisor lowered mid-count may leave the count above the new limit
  a_tick_on_edge: assert property (@(posedge clk) disable iff (!arst_n)
    tick |-> $past(rise) && $past(div_cnt_reg) >= $past(div_last))
    else $error("calibration tick without completed division");

  a_div_decode: assert property (@(posedge clk) disable iff (!arst_n)
    div_last == ((div_sel == DIV_SEL_2) ? 5'h01 : (div_sel == DIV_SEL_4) ? 5'h03 :
                 (div_sel == DIV_SEL_8) ? 5'h07 : 5'h0f))
    else $error("calibration divisor decode wrong");

endmodule

// ===== rtl/vco_cal_pkg.sv
// Shared constants for the oscillator calibration sequencer
package vco_cal_pkg;

  // ----------------------------------------------------------------
  // Register bus
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W = 10;
  localparam int unsigned DATA_W = 8;

  localparam logic [ADDR_W-1:0] CAL_CTRL_ADDR   = 10'h018;
  localparam logic [ADDR_W-1:0] CAL_STATUS_ADDR = 10'h01f;
  localparam logic [ADDR_W-1:0] UPDATE_ADDR     = 10'h232;
  localparam logic [ADDR_W-1:0] IRQ_STATUS_ADDR = 10'h240;
  localparam logic [ADDR_W-1:0] IRQ_MASK_ADDR   = 10'h241;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int unsigned CTRL_START_BIT  = 0;
  localparam int unsigned CTRL_DIV_LSB    = 1;
  localparam int unsigned CTRL_DIV_MSB    = 2;
  localparam int unsigned CTRL_USED_MSB   = 2;
  localparam int unsigned STATUS_DONE_BIT = 6;
  localparam int unsigned UPDATE_BIT      = 0;
  localparam int unsigned IRQ_DONE_BIT    = 0;
  localparam int unsigned IRQ_START_BIT   = 1;
  localparam int unsigned IRQ_W           = 2;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [CTRL_USED_MSB:0] CTRL_RESET     = 3'h0;
  localparam logic [1:0]             DIV_RESET      = 2'h0;
  localparam logic [IRQ_W-1:0]       IRQ_MASK_RESET = 2'h0;

  // ----------------------------------------------------------------
  // Calibration timing
  // ----------------------------------------------------------------
  localparam int unsigned CAL_CYCLES = 4400;
  localparam int unsigned CAL_CNT_W  = 13;
  localparam int unsigned DIV_CNT_W  = 5;

  localparam logic [1:0] DIV_SEL_2  = 2'h0;
  localparam logic [1:0] DIV_SEL_4  = 2'h1;
  localparam logic [1:0] DIV_SEL_8  = 2'h2;
  localparam logic [1:0] DIV_SEL_16 = 2'h3;

  localparam logic [DIV_CNT_W-1:0] DIV_VAL_2  = 5'h02;
  localparam logic [DIV_CNT_W-1:0] DIV_VAL_4  = 5'h04;
  localparam logic [DIV_CNT_W-1:0] DIV_VAL_8  = 5'h08;
  localparam logic [DIV_CNT_W-1:0] DIV_VAL_16 = 5'h10;

  // ----------------------------------------------------------------
  // Sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE   = 3'b001,
    ST_CAL    = 3'b010,
    ST_SETTLE = 3'b100
  } seq_state_type;

endpackage

// ===== rtl/vco_calibration_sequencer.sv
// Oscillator calibration sequencer with register port and interrupt
//
// Behaviour
// - Calibration clock is phase-compare clock divided
// - Each run lasts exactly 4400 calibration cycles
// - First start: set start bit, then update
// - Later starts need applied bit rising zero-to-one
// - Readable done bit set after run finishes
// - Start asserts internal output sync hold
// - Finish releases sync, then closes loop
// - Auto-load at power-up starts a run
// - No self-start on divider register changes
// - Request accepted anytime, restarting full run
`timescale 1ns/1ps
module vco_calibration_sequencer
  import vco_cal_pkg::*;
#(
  parameter int unsigned CYCLES = CAL_CYCLES
) (
  input  wire logic              clk,
  input  wire logic              arst_n,
  input  wire logic              phase_compare_clock,
  input  wire logic              autoload_done,
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic [DATA_W-1:0] wdata,
  input  wire logic              wr_en,
  input  wire logic              rd_en,
  output logic      [DATA_W-1:0] rdata,
  output logic                   irq,
  output logic                   output_sync_hold,
  output logic                   pll_loop_closed
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [CTRL_USED_MSB:0] stage_ctrl_reg;
  logic                   active_start_reg;
  logic [1:0]             active_div_reg;
  logic                   done_reg;
  logic [IRQ_W-1:0]       irq_status_reg;
  logic [IRQ_W-1:0]       irq_mask_reg;
  logic [IRQ_W-1:0]       irq_event;
  seq_state_type          state_reg;
  seq_state_type          state_next;

  logic                   ctrl_write;
  logic                   update_write;
  logic                   host_start;
  logic                   start_req;
  logic                   cal_tick;
  logic                   cal_finished;
  logic                   run_end;

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  assign ctrl_write   = wr_en && (addr == CAL_CTRL_ADDR);
  assign update_write = wr_en && (addr == UPDATE_ADDR) && wdata[UPDATE_BIT];

  // Only the applied start bit rising can launch a host run
  assign host_start = update_write && stage_ctrl_reg[CTRL_START_BIT]
                      && !active_start_reg;

  // Divider or frequency writes never feed this term
  assign start_req = host_start || autoload_done;

  assign run_end = (state_reg == ST_CAL) && cal_finished && !start_req;

  // ----------------------------------------------------------------
  // Staged and applied control
  // ----------------------------------------------------------------
  // Staged bits have no effect until the update strobe copies them
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      stage_ctrl_reg <= CTRL_RESET;
    end else if (ctrl_write) begin
      stage_ctrl_reg <= wdata[CTRL_USED_MSB:0];
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      active_start_reg <= CTRL_RESET[CTRL_START_BIT];
      active_div_reg   <= DIV_RESET;
    end else if (update_write) begin
      active_start_reg <= stage_ctrl_reg[CTRL_START_BIT];
      active_div_reg   <= stage_ctrl_reg[CTRL_DIV_MSB:CTRL_DIV_LSB];
    end
  end

  // ----------------------------------------------------------------
  // Calibration clock and cycle count
  // ----------------------------------------------------------------
  // Relies on a present, stable reference; without one the run stalls
  cal_tick_gen u_tick (
    .clk                 (clk),
    .arst_n              (arst_n),
    .phase_compare_clock (phase_compare_clock),
    .div_sel             (active_div_reg),
    .restart             (start_req),
    .tick                (cal_tick)
  );

  cal_cycle_counter #(
    .CYCLES (CYCLES)
  ) u_count (
    .clk      (clk),
    .arst_n   (arst_n),
    .clear    (start_req),
    .run      (state_reg == ST_CAL),
    .tick     (cal_tick),
    .finished (cal_finished)
  );

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    if (start_req) begin
      state_next = ST_CAL;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          state_next = ST_IDLE;
        end
        ST_CAL: begin
          if (cal_finished) begin
            state_next = ST_SETTLE;
          end
        end
        ST_SETTLE: begin
          state_next = ST_IDLE;
        end
        default: begin
          state_next = ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_reg <= ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // Sync released one cycle before the loop closes
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      output_sync_hold <= 1'b0;
      pll_loop_closed  <= 1'b1;
    end else begin
      output_sync_hold <= (state_next == ST_CAL);
      pll_loop_closed  <= (state_next == ST_IDLE);
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      done_reg <= 1'b0;
    end else if (start_req) begin
      done_reg <= 1'b0;
    end else if (run_end) begin
      done_reg <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Interrupts
  // ----------------------------------------------------------------
  assign irq_event = {start_req, run_end};

  // Set wins over a write-one clear in the same cycle
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      irq_status_reg <= '0;
    end else if (wr_en && (addr == IRQ_STATUS_ADDR)) begin
      irq_status_reg <= (irq_status_reg & ~wdata[IRQ_W-1:0]) | irq_event;
    end else begin
      irq_status_reg <= irq_status_reg | irq_event;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      irq_mask_reg <= IRQ_MASK_RESET;
    end else if (wr_en && (addr == IRQ_MASK_ADDR)) begin
      irq_mask_reg <= wdata[IRQ_W-1:0];
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_status_reg & irq_mask_reg);
    end
  end

  // ----------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rdata <= '0;
    end else if (rd_en) begin
      case (addr)
        CAL_CTRL_ADDR:   rdata <= {5'h00, stage_ctrl_reg};
        CAL_STATUS_ADDR: rdata <= {1'b0, done_reg, 6'h00};
        IRQ_STATUS_ADDR: rdata <= {6'h00, irq_status_reg};
        IRQ_MASK_ADDR:   rdata <= {6'h00, irq_mask_reg};
        default:         rdata <= '0;
      endcase
    end else begin
      rdata <= '0;
    end
  end

  // ----------------------------------------------------------------
  // Check helpers
  // ----------------------------------------------------------------
  // Own tally of ticks per run, so the run length is held against
  // the parameter and not against the counter's own compare
  logic [CAL_CNT_W:0] run_ticks_reg;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      run_ticks_reg <= '0;
    end else if (start_req) begin
      run_ticks_reg <= '0;
    end else if ((state_reg == ST_CAL) && cal_tick) begin
      run_ticks_reg <= run_ticks_reg + 14'h0001;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_update_applies: assert property (@(posedge clk) disable iff (!arst_n)
    update_write |=> active_start_reg == $past(stage_ctrl_reg[CTRL_START_BIT]))
    else $error("update strobe did not apply staged start bit");

  a_host_rise_only: assert property (@(posedge clk) disable iff (!arst_n)
    host_start |=> active_start_reg && !$past(active_start_reg))
    else $error("host start without rising applied bit");

  a_start_holds_sync: assert property (@(posedge clk) disable iff (!arst_n)
    start_req |=> output_sync_hold && !pll_loop_closed)
    else $error("start did not assert output sync");

  a_release_then_close: assert property (@(posedge clk) disable iff (!arst_n)
    $fell(output_sync_hold) |-> !pll_loop_closed ##1
      (pll_loop_closed || output_sync_hold))
    else $error("loop not closed one cycle after sync release");

  a_done_after_run: assert property (@(posedge clk) disable iff (!arst_n)
    run_end |=> done_reg && !output_sync_hold)
    else $error("done bit not set at end of run");

  a_done_low_running: assert property (@(posedge clk) disable iff (!arst_n)
    output_sync_hold |-> !done_reg)
    else $error("done bit high during calibration");

  a_no_self_start: assert property (@(posedge clk) disable iff (!arst_n)
    $rose(output_sync_hold) |-> $past(host_start) || $past(autoload_done))
    else $error("calibration began without a trigger");

  a_autoload_start: assert property (@(posedge clk) disable iff (!arst_n)
    autoload_done |=> output_sync_hold ##1 output_sync_hold)
    else $error("auto-load did not start calibration");

  a_restart_anytime: assert property (@(posedge clk) disable iff (!arst_n)
    start_req && output_sync_hold |=> output_sync_hold && !done_reg)
    else $error("request during run was not accepted");

  a_irq_level: assert property (@(posedge clk) disable iff (!arst_n)
    |(irq_status_reg & irq_mask_reg) |=> irq)
    else $error("interrupt not raised for unmasked status");

  a_run_tick_total: assert property (@(posedge clk) disable iff (!arst_n)
    run_end |-> run_ticks_reg == CYCLES)
    else $error("run ended after wrong number of ticks");

  a_tick_bound: assert property (@(posedge clk) disable iff (!arst_n)
    (state_reg == ST_CAL) |-> run_ticks_reg <= CYCLES)
    else $error("run counted past its length");

  a_loop_open_hold: assert property (@(posedge clk) disable iff (!arst_n)
    output_sync_hold |-> !pll_loop_closed)
    else $error("loop closed while outputs held");

  a_close_after_release: assert property (@(posedge clk) disable iff (!arst_n)
    $rose(pll_loop_closed) |-> !output_sync_hold && !$past(output_sync_hold))
    else $error("loop closed before sync release");

  a_settle_then_idle: assert property (@(posedge clk) disable iff (!arst_n)
    (state_reg == ST_SETTLE) && !start_req |=> (state_reg == ST_IDLE) && pll_loop_closed)
    else $error("loop not closed after settle cycle");

  a_done_sticky: assert property (@(posedge clk) disable iff (!arst_n)
    done_reg && !start_req |=> done_reg)
    else $error("done bit lost without a new start");

  a_done_at_end: assert property (@(posedge clk) disable iff (!arst_n)
    $rose(done_reg) |-> $past(run_end))
    else $error("done bit set outside run end");

  a_done_readback: assert property (@(posedge clk) disable iff (!arst_n)
    $past(rd_en) && ($past(addr) == CAL_STATUS_ADDR) |->
      rdata[STATUS_DONE_BIT] == $past(done_reg))
    else $error("done bit not returned on status read");

  a_staged_readback: assert property (@(posedge clk) disable iff (!arst_n)
    $past(rd_en) && ($past(addr) == CAL_CTRL_ADDR) |->
      rdata[CTRL_USED_MSB:0] == $past(stage_ctrl_reg))
    else $error("staged control not returned on read");

  a_rdata_idle: assert property (@(posedge clk) disable iff (!arst_n)
    !$past(rd_en) |-> rdata == '0)
    else $error("read data not zero outside a read");

  a_irq_low_masked: assert property (@(posedge clk) disable iff (!arst_n)
    !(|(irq_status_reg & irq_mask_reg)) |=> !irq)
    else $error("interrupt raised without unmasked status");

  a_start_flag_set: assert property (@(posedge clk) disable iff (!arst_n)
    start_req |=> irq_status_reg[IRQ_START_BIT])
    else $error("start status flag not set");

  a_end_flag_set: assert property (@(posedge clk) disable iff (!arst_n)
    run_end |=> irq_status_reg[IRQ_DONE_BIT])
    else $error("finish status flag not set");

  a_refused_update: assert property (@(posedge clk) disable iff (!arst_n)
    update_write && active_start_reg && !autoload_done |=> !$rose(output_sync_hold))
    else $error("update with applied start high began a run");

  a_divider_no_start: assert property (@(posedge clk) disable iff (!arst_n)
    ctrl_write && !autoload_done |=> !$rose(output_sync_hold))
    else $error("control write began a run");

endmodule

// ===== verification/pcc_source.sv
// Reference source model feeding the phase-compare clock pin
`timescale 1ns/1ps
module pcc_source #(
  parameter int unsigned HALF = 4
) (
  input  wire logic clk,
  input  wire logic en,
  output logic      pcc
);
  int unsigned cnt;
  // Free-running stable source once enabled
  initial begin
    pcc = 1'b0;
    cnt = 0;
  end
  always @(posedge clk) begin
    if (en) begin
      cnt = cnt + 1;
      if (cnt >= HALF) begin
        cnt = 0;
        pcc <= ~pcc;
      end
    end
  end
endmodule

// ===== verification/tb_top.sv
// Testbench for the oscillator calibration sequencer
`timescale 1ns/1ps
module tb_top;
  import vco_cal_pkg::*;
  localparam int unsigned NCYC = 4;
  logic              clk = 1'b0;
  logic              arst_n = 1'b0;
  logic              ref_en = 1'b0;
  logic              pcc;
  logic              autoload_done = 1'b0;
  logic [ADDR_W-1:0] addr = '0;
  logic [DATA_W-1:0] wdata = '0;
  logic              wr_en = 1'b0;
  logic              rd_en = 1'b0;
  logic [DATA_W-1:0] rdata;
  logic              irq;
  logic              output_sync_hold;
  logic              pll_loop_closed;
  int                mismatches = 0;
  int                n_tests = 0;
  int                edges = 0;
  int                exp_ticks;

  always #12.5 clk = ~clk;

  pcc_source #(.HALF(4)) src (.clk(clk), .en(ref_en), .pcc(pcc));

  vco_calibration_sequencer #(.CYCLES(NCYC)) DUT (
    .clk(clk), .arst_n(arst_n), .phase_compare_clock(pcc), .autoload_done(autoload_done),
    .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .irq(irq),
    .output_sync_hold(output_sync_hold), .pll_loop_closed(pll_loop_closed));

  // Pin edges seen while outputs are held; sync latency allows a slack of one
  always @(posedge pcc) if (output_sync_hold === 1'b1) edges++;

  // ----------------------------------------------------------------
  // Access tasks
  // ----------------------------------------------------------------
  task automatic chk(input string nm, input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
    n_tests++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask

  task automatic rd(input string nm, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
    @(posedge clk);
    addr  <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    #1;
    chk(nm, rdata, e);
  endtask

  // Loop registers and feedback select sit outside
  task automatic start(input logic [1:0] s);
    wr(CAL_CTRL_ADDR, {5'h00, s, 1'b0});
    wr(UPDATE_ADDR, 8'h01);
    wr(CAL_CTRL_ADDR, {5'h00, s, 1'b1});
    wr(UPDATE_ADDR, 8'h01);
    @(posedge clk);
    #1;
    edges = 0;
    chk("hold_on_start", output_sync_hold, 1'b1);
    chk("loop_open", pll_loop_closed, 1'b0);
  endtask

  task automatic wait_end();
    int n;
    n = 0;
    while (output_sync_hold === 1'b1 && n < 20000) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk("run_ended", output_sync_hold, 8'h00);
    chk("ticks_in_range", 8'((edges + 1 >= exp_ticks) && (edges <= exp_ticks + 1)), 8'h01);
    chk("loop_at_release", pll_loop_closed, 1'b0);
    @(posedge clk);
    #1;
    chk("loop_closed", pll_loop_closed, 1'b1);
    rd("done_bit", CAL_STATUS_ADDR, 8'h40);
  endtask

  // ----------------------------------------------------------------
  // Closing
  // ----------------------------------------------------------------
  task automatic results();
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  initial begin
    repeat (30000) @(posedge clk);
    mismatches++;
    results();
  end

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    ref_en = 1'b1;
    repeat (4) @(posedge clk);
    arst_n <= 1'b1;
    #1;
    chk("irq_reset", irq, 1'b0);
    chk("hold_reset", output_sync_hold, 1'b0);
    chk("loop_reset", pll_loop_closed, 1'b1);
    rd("ctrl_reset", CAL_CTRL_ADDR, 8'h00);
    rd("mask_reset", IRQ_MASK_ADDR, 8'h00);
    rd("update_reads0", UPDATE_ADDR, 8'h00);
    rd("unmapped", 10'h3ff, 8'h00);
    $display("test reset done");

    // Every divider code; irq unmasked only on the first run
    for (int i = 0; i < 4; i++) begin
      wr(IRQ_MASK_ADDR, (i == 0) ? 8'h01 : 8'h00);
      exp_ticks = NCYC * (2 << i);
      start(2'(i));
      rd("done_low_in_run", CAL_STATUS_ADDR, 8'h00);
      rd("ctrl_staged", CAL_CTRL_ADDR, {5'h00, 2'(i), 1'b1});
      wait_end();
      @(posedge clk);
      #1;
      chk("irq_level", irq, (i == 0));
      rd("irq_status", IRQ_STATUS_ADDR, 8'h03);
      wr(IRQ_STATUS_ADDR, 8'h03);
      rd("irq_cleared", IRQ_STATUS_ADDR, 8'h00);
      chk("irq_low", irq, 1'b0);
    end
    $display("test divider codes done");

    // Applied start already one: neither a repeat update nor a divider change starts
    wr(UPDATE_ADDR, 8'h01);
    wr(CAL_CTRL_ADDR, 8'h03);
    wr(UPDATE_ADDR, 8'h01);
    repeat (3) @(posedge clk);
    #1;
    chk("no_restart", output_sync_hold, 1'b0);
    rd("done_kept", CAL_STATUS_ADDR, 8'h40);
    $display("test refused start done");

    // Start in mid-run restarts the full count
    exp_ticks = NCYC * 2;
    start(2'h0);
    repeat (10) @(posedge clk);
    start(2'h0);
    rd("done_low_restart", CAL_STATUS_ADDR, 8'h00);
    wait_end();
    $display("test restart done");

    // Power-up load completion starts a run by itself
    @(posedge clk);
    autoload_done <= 1'b1;
    @(posedge clk);
    autoload_done <= 1'b0;
    @(posedge clk);
    #1;
    edges = 0;
    chk("autoload_hold", output_sync_hold, 1'b1);
    wait_end();
    $display("test autoload done");
    results();
  end
endmodule
